/* File: rtl/usfe_pkg.sv */
// package for the serial frame status and enable block
// assumes an Avalon-MM slave with byte addresses and 32-bit data
package usfe_pkg;
    // ========================================
    // register indices and byte addresses
    localparam logic [11:0] USFE_IDX_RX_HOLD  = 12'hF40;
    localparam logic [11:0] USFE_IDX_STATUS0  = 12'hF41;
    localparam logic [11:0] USFE_IDX_CTRL0    = 12'hF42;
    localparam logic [11:0] USFE_IDX_CTRL1    = 12'hF43;
    localparam logic [11:0] USFE_IDX_STATUS1  = 12'hF44;
    localparam int          USFE_ADDR_W       = 14;
    localparam logic [13:0] USFE_ADDR_RX_HOLD = {USFE_IDX_RX_HOLD, 2'h0};
    localparam logic [13:0] USFE_ADDR_STATUS0 = {USFE_IDX_STATUS0, 2'h0};
    localparam logic [13:0] USFE_ADDR_CTRL0   = {USFE_IDX_CTRL0, 2'h0};
    localparam logic [13:0] USFE_ADDR_CTRL1   = {USFE_IDX_CTRL1, 2'h0};
    localparam logic [13:0] USFE_ADDR_STATUS1 = {USFE_IDX_STATUS1, 2'h0};
    // ========================================
    // field positions
    localparam int USFE_C0_TX_ON      = 7;
    localparam int USFE_C0_RX_ON      = 6;
    localparam int USFE_C0_CTS_GATE   = 5;
    localparam int USFE_C1_NINTH_MODE = 6;
    localparam int USFE_S1_FIRST_BYTE = 1;
    localparam int USFE_S1_NINTH_BIT  = 0;
    localparam int USFE_S0_CTS_LEVEL  = 0;
    // ========================================
    // reset values
    localparam logic [7:0] USFE_CTRL0_RST   = 8'h00;
    localparam logic [7:0] USFE_CTRL1_RST   = 8'h00;
    localparam logic [7:0] USFE_RX_HOLD_RST = 8'h00;
endpackage

/* File: rtl/usfe_sync.sv */
// two flip-flop synchroniser for one level from a pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
module usfe_sync (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic rst_val_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_r;

    // rst_val_i must be a constant tie at the instance
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_r <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule

/* File: rtl/usfe_top.sv */
// serial port frame status, ninth bit capture and transmit/receive enables
// assumes the receiver delivers bytes on clk_i and cts_b_i comes from a pin
// How it works
// RULE1: software writes zeros to reserved status bits
// RULE2: new-frame flag set for frame's first byte
// RULE3: new-frame flag zero for any other byte
// RULE4: reading received byte clears new-frame flag
// RULE5: status bit 0 shows last ninth bit
// RULE6: reading received byte clears captured ninth bit
// RULE7: software changes control only while disabled
// RULE8: control bit 7 turns transmitter on
// RULE9: gated transmitter runs only with clear-to-send low
// RULE10: control bit 6 turns receiver on
// RULE11: status read returns present clear-to-send level
// RULE12: control bit selects nine-bit mode
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module usfe_top
    import usfe_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [USFE_ADDR_W-1:0] avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic [31:0]                 avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic                   cts_b_i,
    input  wire logic                   rx_byte_valid_i,
    input  wire logic [7:0]             rx_byte_i,
    input  wire logic                   rx_ninth_i,
    input  wire logic                   rx_frame_start_i,
    output logic                        tx_enable_o,
    output logic                        rx_enable_o,
    output logic                        ninth_bit_mode_o
);
    // ========================================
    // state
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] rx_hold_r;
    logic       first_byte_of_frame_flag_r;
    logic       ninth_bit_received_r;
    logic       cts_b_sync;

    usfe_sync u_cts_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .rst_val_i (1'b1),
        .async_i   (cts_b_i),
        .sync_o    (cts_b_sync)
    );

    // ========================================
    // bus decode
    // every access waits exactly one cycle; read data is latched in that cycle
    wire       req_new   = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    wire       acc_done  = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    wire       sel_hold  = (avs_address_i == USFE_ADDR_RX_HOLD);
    wire       sel_st0   = (avs_address_i == USFE_ADDR_STATUS0);
    wire       sel_c0    = (avs_address_i == USFE_ADDR_CTRL0);
    wire       sel_c1    = (avs_address_i == USFE_ADDR_CTRL1);
    wire       sel_st1   = (avs_address_i == USFE_ADDR_STATUS1);
    wire       wr_lane0  = acc_done & avs_write_i & avs_byteenable_i[0];
    // RULE7 is left to software: writes while enabled are taken as given
    wire       wr_c0     = wr_lane0 & sel_c0;
    wire       wr_c1     = wr_lane0 & sel_c1;
    wire       rd_hold   = acc_done & avs_read_i & sel_hold;
    wire [7:0] status0   = {7'h00, cts_b_sync};                            // RULE11
    // reserved bits read zero; writes here are ignored
    wire [7:0] status1   = {6'h00, first_byte_of_frame_flag_r, ninth_bit_received_r}; // RULE1
    wire [7:0] rd_mux    = sel_hold ? rx_hold_r :
                           sel_st0  ? status0 :
                           sel_c0   ? ctrl0_r :
                           sel_c1   ? ctrl1_r :
                           sel_st1  ? status1 : 8'h00;
    wire [7:0] ctrl0_nxt = wr_c0 ? avs_writedata_i[7:0] : ctrl0_r;
    wire [7:0] ctrl1_nxt = wr_c1 ? avs_writedata_i[7:0] : ctrl1_r;

    // ========================================
    // receive capture
    wire       ninth_mode = ctrl1_r[USFE_C1_NINTH_MODE];                  // RULE12
    // a byte arriving with the clearing read wins over the clear
    wire       flag_nxt   = rx_byte_valid_i ? rx_frame_start_i :          // RULE2 RULE3
                            rd_hold         ? 1'b0 : first_byte_of_frame_flag_r; // RULE4
    wire       ninth_nxt  = rx_byte_valid_i ? (ninth_mode & rx_ninth_i) : // RULE5
                            rd_hold         ? 1'b0 : ninth_bit_received_r; // RULE6
    wire [7:0] hold_nxt   = rx_byte_valid_i ? rx_byte_i : rx_hold_r;

    // ========================================
    // enables
    wire tx_on_nxt = ctrl0_r[USFE_C0_TX_ON] &                              // RULE8
                     (~ctrl0_r[USFE_C0_CTS_GATE] | ~cts_b_sync);           // RULE9
    wire rx_on_nxt = ctrl0_r[USFE_C0_RX_ON];                               // RULE10

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl0_r <= USFE_CTRL0_RST;
            ctrl1_r <= USFE_CTRL1_RST;
        end else begin
            ctrl0_r <= ctrl0_nxt;
            ctrl1_r <= ctrl1_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_hold_r                  <= USFE_RX_HOLD_RST;
            first_byte_of_frame_flag_r <= 1'b0;
            ninth_bit_received_r       <= 1'b0;
        end else begin
            rx_hold_r                  <= hold_nxt;
            first_byte_of_frame_flag_r <= flag_nxt;
            ninth_bit_received_r       <= ninth_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~req_new;
            if (req_new && avs_read_i) begin
                avs_readdata_o <= {24'h00_0000, rd_mux};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tx_enable_o      <= 1'b0;
            rx_enable_o      <= 1'b0;
            ninth_bit_mode_o <= 1'b0;
        end else begin
            tx_enable_o      <= tx_on_nxt;
            rx_enable_o      <= rx_on_nxt;
            ninth_bit_mode_o <= ninth_mode;
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_byte_in;
        rx_byte_valid_i;
    endsequence

    sequence s_hold_read_alone;
        rd_hold && !rx_byte_valid_i;
    endsequence

    AST_FLAG_SET: assert property (s_byte_in |=> first_byte_of_frame_flag_r == $past(rx_frame_start_i)) // RULE2
        else $error("new-frame flag does not follow frame start");
    AST_FLAG_ZERO: assert property ((s_byte_in and !rx_frame_start_i) |=> !first_byte_of_frame_flag_r) // RULE3
        else $error("new-frame flag set for a non-first byte");
    AST_FLAG_CLR: assert property (s_hold_read_alone |=> !first_byte_of_frame_flag_r) // RULE4
        else $error("new-frame flag survives a holding read");
    AST_NINTH_CAP: assert property ((s_byte_in and ninth_mode) |=> ninth_bit_received_r == $past(rx_ninth_i)) // RULE5
        else $error("ninth bit not captured");
    AST_NINTH_CLR: assert property (s_hold_read_alone |=> !ninth_bit_received_r) // RULE6
        else $error("ninth bit survives a holding read");
    AST_TX_OFF: assert property (!ctrl0_r[USFE_C0_TX_ON] |=> !tx_enable_o) // RULE8
        else $error("transmitter on while its bit is clear");
    AST_TX_GATE: assert property (ctrl0_r[USFE_C0_CTS_GATE] && cts_b_sync |=> !tx_enable_o) // RULE9
        else $error("transmitter on with clear-to-send high");
    AST_RX_ON: assert property (##1 rx_enable_o == $past(ctrl0_r[USFE_C0_RX_ON])) // RULE10
        else $error("receiver enable does not follow its bit");
    AST_CTS_READ: assert property (req_new && avs_read_i && sel_st0
        |=> avs_readdata_o[USFE_S0_CTS_LEVEL] == $past(cts_b_sync)) // RULE11
        else $error("status read misses clear-to-send level");
    AST_NINTH_MODE_OFF: assert property ((s_byte_in and !ninth_mode) |=> !ninth_bit_received_r) // RULE12
        else $error("ninth bit captured outside nine-bit mode");
    AST_WAIT_ONE: assert property (req_new |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not low for exactly one cycle");

    // ========================================
    // bus answer checks
    sequence s_idle_bus;
        !avs_read_i && !avs_write_i;
    endsequence

    sequence s_st1_read;
        req_new && avs_read_i && sel_st1;
    endsequence

    AST_WQ_IDLE: assert property (s_idle_bus |=> avs_waitrequest_o)
        else $error("waitrequest low with no request");
    AST_WQ_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for two cycles");

    AST_RD_UPPER: assert property (avs_readdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");
    AST_RD_KEEP: assert property (!(req_new && avs_read_i) |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    AST_RD_UNMAPPED: assert property (req_new && avs_read_i
        && !(sel_hold || sel_st0 || sel_c0 || sel_c1 || sel_st1) |=> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    AST_RD_HOLD: assert property (req_new && avs_read_i && sel_hold |=> avs_readdata_o[7:0] == $past(rx_hold_r))
        else $error("holding read returned wrong byte");
    AST_RD_C0: assert property (req_new && avs_read_i && sel_c0 // RULE8 RULE10
        |=> avs_readdata_o[7:0] == $past(ctrl0_r))
        else $error("control zero read back wrong");
    AST_RD_C1: assert property (req_new && avs_read_i && sel_c1 // RULE12
        |=> avs_readdata_o[7:0] == $past(ctrl1_r))
        else $error("control one read back wrong");
    AST_RD_ST0_RSVD: assert property (req_new && avs_read_i && sel_st0 |=> avs_readdata_o[7:1] == 7'h00)
        else $error("status zero spare bits not zero");

    AST_ST1_FLAG: assert property (s_st1_read // RULE2
        |=> avs_readdata_o[USFE_S1_FIRST_BYTE] == $past(first_byte_of_frame_flag_r))
        else $error("status one read misses new-frame flag");
    AST_ST1_NINTH: assert property (s_st1_read // RULE5
        |=> avs_readdata_o[USFE_S1_NINTH_BIT] == $past(ninth_bit_received_r))
        else $error("status one read misses ninth bit");
    AST_ST1_RSVD: assert property (s_st1_read |=> avs_readdata_o[7:2] == 6'h00)
        else $error("status one reserved bits not zero");

    // ========================================
    // register write checks
    // a write is taken, then held until the answer edge, where it lands
    sequence s_c0_write_done;
        (req_new && avs_write_i && sel_c0) ##1
        (!avs_waitrequest_o && avs_write_i && sel_c0 && avs_byteenable_i[0]);
    endsequence

    sequence s_c1_write_done;
        (req_new && avs_write_i && sel_c1) ##1
        (!avs_waitrequest_o && avs_write_i && sel_c1 && avs_byteenable_i[0]);
    endsequence

    sequence s_masked_write_done;
        (req_new && avs_write_i && !avs_byteenable_i[0]) ##1
        (!avs_waitrequest_o && avs_write_i && !avs_byteenable_i[0]);
    endsequence

    AST_C0_WRITE: assert property (s_c0_write_done |=> ctrl0_r == $past(avs_writedata_i[7:0])) // RULE8 RULE10
        else $error("control zero write did not land");
    AST_C1_WRITE: assert property (s_c1_write_done |=> ctrl1_r == $past(avs_writedata_i[7:0])) // RULE12
        else $error("control one write did not land");
    AST_MASKED_WRITE: assert property (s_masked_write_done |=> $stable(ctrl0_r) && $stable(ctrl1_r))
        else $error("write with lane zero disabled changed a register");
    AST_CTRL_KEEP: assert property (s_idle_bus |=> $stable(ctrl0_r) && $stable(ctrl1_r))
        else $error("control register changed with the bus idle");

    // ========================================
    // enable checks
    sequence s_cts_low_twice;
        !cts_b_i ##1 !cts_b_i;
    endsequence

    AST_TX_ON: assert property (ctrl0_r[USFE_C0_TX_ON] && !ctrl0_r[USFE_C0_CTS_GATE] |=> tx_enable_o) // RULE8
        else $error("ungated transmitter off while its bit is set");
    AST_TX_OPEN: assert property (ctrl0_r[USFE_C0_TX_ON] && ctrl0_r[USFE_C0_CTS_GATE] // RULE9
        && !cts_b_sync |=> tx_enable_o)
        else $error("gated transmitter off with clear-to-send low");
    // the pin reaches the enable through two sync stages and the output flop
    AST_TX_FROM_PIN: assert property (s_cts_low_twice ##1 // RULE9
        (ctrl0_r[USFE_C0_TX_ON] && ctrl0_r[USFE_C0_CTS_GATE]) |=> tx_enable_o)
        else $error("clear-to-send low at the pin did not open the transmitter");
    AST_TX_BIT: assert property (tx_enable_o |-> $past(ctrl0_r[USFE_C0_TX_ON])) // RULE8
        else $error("transmitter on without its bit");
    AST_TX_FROM_WRITE: assert property ((s_c0_write_done ##0 !avs_writedata_i[USFE_C0_TX_ON]) // RULE8
        |=> ##1 !tx_enable_o)
        else $error("transmitter on after its bit was written zero");
    AST_RX_OFF: assert property (!ctrl0_r[USFE_C0_RX_ON] |=> !rx_enable_o) // RULE10
        else $error("receiver on while its bit is clear");
    AST_RX_FROM_WRITE: assert property (s_c0_write_done // RULE10
        |=> ##1 rx_enable_o == $past(avs_writedata_i[USFE_C0_RX_ON], 2))
        else $error("receiver enable does not follow the written bit");
    AST_CTS_SYNC: assert property (##2 cts_b_sync == $past(cts_b_i, 2)) // RULE11
        else $error("clear-to-send level not two stages behind the pin");

    AST_MODE_OUT: assert property (##1 ninth_bit_mode_o == $past(ninth_mode)) // RULE12
        else $error("nine-bit mode output does not follow its bit");
    AST_MODE_FROM_WRITE: assert property (s_c1_write_done // RULE12
        |=> ##1 ninth_bit_mode_o == $past(avs_writedata_i[USFE_C1_NINTH_MODE], 2))
        else $error("nine-bit mode output does not follow the written bit");

    // ========================================
    // receive holding checks
    sequence s_hold_read_done;
        (req_new && avs_read_i && sel_hold) ##1
        (!avs_waitrequest_o && avs_read_i && sel_hold && !rx_byte_valid_i);
    endsequence

    AST_HOLD_CAP: assert property (s_byte_in |=> rx_hold_r == $past(rx_byte_i))
        else $error("received byte not held");
    AST_HOLD_KEEP: assert property (!rx_byte_valid_i |=> $stable(rx_hold_r))
        else $error("held byte changed without a new byte");
    AST_FLAG_KEEP: assert property (!rx_byte_valid_i && !rd_hold |=> $stable(first_byte_of_frame_flag_r)) // RULE3
        else $error("new-frame flag changed with no byte and no read");
    AST_NINTH_KEEP: assert property (!rx_byte_valid_i && !rd_hold |=> $stable(ninth_bit_received_r)) // RULE5
        else $error("ninth bit changed with no byte and no read");
    // the read only clears when no byte lands in the same cycle
    AST_READ_CLEARS: assert property (s_hold_read_done // RULE4 RULE6
        |=> !first_byte_of_frame_flag_r && !ninth_bit_received_r)
        else $error("holding read on the bus left status set");
endmodule

/* File: bench/usfe_remote.sv */
// far-side model: remote serial receiver delivering bytes to the block
// assumes the bench asks for one byte at a time with send_i
`timescale 1ns/100ps
module usfe_remote (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       send_i,
    input  wire logic [7:0] data_i,
    input  wire logic       start_i,
    input  wire logic       ninth_i,
    output logic            valid_o,
    output logic [7:0]      byte_o,
    output logic            start_o,
    output logic            ninth_o
);
    // ========================================
    // one-cycle strobe; lines churn outside it so stale data never looks valid
    always @(posedge clk_i) begin
        if (!rst_b_i) {valid_o, byte_o, start_o, ninth_o} <= 11'h000;
        else begin
            valid_o <= send_i;
            if (send_i) {byte_o, start_o, ninth_o} <= {data_i, start_i, ninth_i};
            else {byte_o, start_o, ninth_o} <= ~{byte_o, start_o, ninth_o};
        end
    end
endmodule

/* File: bench/usfe_top_tb_top.sv */
// self-checking bench for the frame status and enable block
// assumes the remote model and the design package are compiled first
`timescale 1ns/100ps
module usfe_top_tb_top;
    import usfe_pkg::*;
    logic        clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, cts = 1, snd = 0, ss = 0, sn = 0;
    logic [13:0] ad = 0;
    logic [31:0] wd = 0, rdat, r, lf = 32'h807FDB3D;
    logic [3:0]  be = 4'hF;
    logic [7:0]  sd = 0, b;
    logic        v, fs, n9, txe, rxe, m9, wq;
    int          fails = 0, n_checks = 0, fl = 0, nb = 0, md = 0;
    usfe_remote rem (.clk_i(clk_i), .rst_b_i(rst_b_i), .send_i(snd), .data_i(sd), .start_i(ss),
        .ninth_i(sn), .valid_o(v), .byte_o(b), .start_o(fs), .ninth_o(n9));
    usfe_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(ad), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .cts_b_i(cts), .rx_byte_valid_i(v), .rx_byte_i(b),
        .rx_ninth_i(n9), .rx_frame_start_i(fs), .tx_enable_o(txe), .rx_enable_o(rxe),
        .ninth_bit_mode_o(m9));
    // ========================================
    // helpers
    function logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge clk_i);
        ad <= a; wd <= d; rd <= !w; wr <= w;
        do @(posedge clk_i); while (wq !== 1'b0);
        r = rdat;
        rd <= 0; wr <= 0;
    endtask
    task rx(input logic [7:0] d, input logic s, input logic n);
        @(posedge clk_i);
        sd <= d; ss <= s; sn <= n; snd <= 1;
        @(posedge clk_i);
        snd <= 0;
        @(posedge clk_i);
        fl = s;
        nb = md ? n : 0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ========================================
    // clock, watchdog, tests
    initial forever #50 clk_i = ~clk_i;
    initial begin
        #2000000;
        fails++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1;
        acc(0, USFE_ADDR_CTRL0, 0); chk(r, 0);
        acc(0, USFE_ADDR_STATUS1, 0); chk(r, 0);
        acc(1, USFE_ADDR_STATUS1, 0);
        acc(0, 14'h0040, 0); chk(r, 0);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            md = k;
            acc(1, USFE_ADDR_CTRL1, 32'(k) << 6);
            repeat (2) @(posedge clk_i);
            chk(m9, k);
            for (int i = 0; i < 8; i++) begin
                lf = nx(lf);
                rx(lf[7:0], lf[8] | (i == 0), lf[9] | (i == 0));
                acc(0, USFE_ADDR_STATUS1, 0); chk(r, {fl[0], nb[0]});
                if (lf[10]) begin
                    acc(0, USFE_ADDR_RX_HOLD, 0); chk(r, lf[7:0]);
                    acc(0, USFE_ADDR_STATUS1, 0); chk(r, 0);
                end
            end
        end
        $display("test frame status done");
        for (int i = 0; i < 16; i++) begin
            cts <= i[3];
            acc(1, USFE_ADDR_CTRL0, 0);
            acc(1, USFE_ADDR_CTRL0, {i[2:0], 5'h00});
            repeat (4) @(posedge clk_i);
            chk(txe, i[2] & (!i[0] | !i[3]));
            chk(rxe, i[1]);
            acc(0, USFE_ADDR_STATUS0, 0); chk(r[0], i[3]);
        end
        acc(1, USFE_ADDR_CTRL0, 0);
        be <= 4'hE;
        acc(1, USFE_ADDR_CTRL0, 32'h000000FF);
        be <= 4'hF;
        acc(0, USFE_ADDR_CTRL0, 0); chk(r, 0);
        $display("test enables done");
        stop_test;
    end
endmodule
